// File: rtl/usc_uart.sv
`timescale 1ns/1ps
`include "usc_map.svh"
module usc_uart #(
  parameter int DEPTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin,
  output logic             tx_pin_owned,
  output logic             rx_pin_owned,
  output logic             tx_irq
);
  // ==========================================
  // registers
  usc_pkg::usc_ctrl_s ctrl;
  logic        module_on;
  logic        infrared_encode_enable;
  logic        break_request;
  logic        acc;
  logic        wr;
  logic        fifo_in_ready;
  logic [7:0]  fifo_out;
  logic        fifo_valid;
  logic        fifo_pop;
  logic        tx_enabled;
  logic        tx_flush;
  logic        tx_shift_empty_flag;
  logic [7:0]  rx_buf;
  logic        rx_data_available;
  logic        addr_matched;
  // apb access phase strobes and transmitter gating
  assign acc        = psel && penable;
  assign wr         = acc && pwrite;
  assign tx_enabled = ctrl.transmitter_enable_bit && module_on;
  assign tx_flush   = !ctrl.transmitter_enable_bit;
  // control fields written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                   <= '0;
      module_on              <= 1'b0;
      infrared_encode_enable <= 1'b0;
    end else if (wr && paddr == `USC_ADDR_STA) begin
      ctrl.auto_addr_detect_enable <= pwdata[`USC_AUTO_ADDR_DETECT_ENABLE_BIT];
      ctrl.addr_char               <= pwdata[`USC_ADDR_LSB +: 8];
      ctrl.tx_irq_mode_select      <= usc_pkg::usc_txi_e'(pwdata[`USC_TXISEL_LSB +: 2]);
      ctrl.tx_polarity_invert      <= pwdata[`USC_TXINV_BIT];
      ctrl.receiver_enable_bit     <= pwdata[`USC_RXEN_BIT];
      ctrl.transmitter_enable_bit  <= pwdata[`USC_TXEN_BIT];
    end else if (wr && paddr == `USC_ADDR_MODE) begin
      module_on              <= pwdata[`USC_ON_BIT];
      infrared_encode_enable <= pwdata[`USC_INFRARED_ENCODE_ENABLE_BIT];
    end
  end
  // ==========================================
  // apb read path, zero-wait answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {`USC_ADDR_STA, `USC_ADDR_MODE,
                 `USC_ADDR_TXDATA, `USC_ADDR_RXDATA});
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `USC_ADDR_STA: prdata <= {7'h00, ctrl.auto_addr_detect_enable, ctrl.addr_char,
            ctrl.tx_irq_mode_select, ctrl.tx_polarity_invert, ctrl.receiver_enable_bit,
            break_request, ctrl.transmitter_enable_bit, !fifo_in_ready, tx_shift_empty_flag,
            7'h00, rx_data_available};
          `USC_ADDR_MODE: prdata <= {16'h0000, module_on, 2'h0, infrared_encode_enable,
            12'h000};
          `USC_ADDR_RXDATA: prdata <= {24'h000000, rx_buf};
          default: prdata <= '0;
        endcase
      end
    end
  end
  // ==========================================
  // baud tick divider, one enable pulse per bit
  logic [15:0] baud_cnt;
  logic        bit_tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt <= '0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= (baud_cnt == `USC_BAUD_DIV);
      baud_cnt <= (baud_cnt == `USC_BAUD_DIV) ? 16'h0000 : 16'(baud_cnt + 1'b1);
    end
  end
  // ==========================================
  // transmit buffer; writes while full are dropped
  usc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txq (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (tx_flush),
    .in_data   (pwdata[7:0]),
    .in_valid  (wr && paddr == `USC_ADDR_TXDATA && tx_enabled),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  // ==========================================
  // transmit shifter
  usc_pkg::usc_tx_e tx_state;
  logic [11:0] shreg;
  logic [3:0]  bit_cnt;
  logic [3:0]  bit_last;
  logic        tx_bit;
  logic        brk_active;
  // a pending break goes out first; the queued character waits for the next idle tick
  assign fifo_pop = tx_enabled && tx_state == usc_pkg::USC_TX_IDLE && bit_tick
                    && fifo_valid && !break_request;
  // every step waits for the shared tick, so bit times cannot drift apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state   <= usc_pkg::USC_TX_IDLE;
      shreg      <= '0;
      bit_cnt    <= '0;
      bit_last   <= '0;
      tx_bit     <= 1'b1;
      brk_active <= 1'b0;
    end else if (!tx_enabled) begin
      tx_state   <= usc_pkg::USC_TX_IDLE;
      tx_bit     <= 1'b1;
      brk_active <= 1'b0;
    end else if (bit_tick) begin
      unique case (tx_state)
        usc_pkg::USC_TX_IDLE: begin
          tx_bit <= 1'b1;
          if (break_request) begin
            shreg      <= '0;
            bit_last   <= 4'(`USC_BRK_ZEROS - 1);
            brk_active <= 1'b1;
            tx_bit     <= 1'b0;
            tx_state   <= usc_pkg::USC_TX_START;
          end else if (fifo_valid) begin
            shreg    <= {4'h0, fifo_out};
            bit_last <= 4'(`USC_DATA_BITS - 1);
            tx_bit   <= 1'b0;
            tx_state <= usc_pkg::USC_TX_START;
          end
        end
        usc_pkg::USC_TX_START: begin
          tx_bit   <= shreg[0];
          shreg    <= {1'b0, shreg[11:1]};
          bit_cnt  <= '0;
          tx_state <= usc_pkg::USC_TX_DATA;
        end
        usc_pkg::USC_TX_DATA: begin
          if (bit_cnt == bit_last) begin
            tx_bit   <= 1'b1;
            tx_state <= usc_pkg::USC_TX_STOP;
          end else begin
            tx_bit  <= shreg[0];
            shreg   <= {1'b0, shreg[11:1]};
            bit_cnt <= 4'(bit_cnt + 1'b1);
          end
        end
        usc_pkg::USC_TX_STOP: begin
          brk_active <= 1'b0;
          tx_state   <= usc_pkg::USC_TX_IDLE;
        end
      endcase
    end
  end
  // break request: software sets, hardware clears at stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_request <= 1'b0;
    end else if (wr && paddr == `USC_ADDR_STA && pwdata[`USC_BRK_BIT]) begin
      break_request <= 1'b1; // a new set wins over completion
    end else if (brk_active && bit_tick && tx_state == usc_pkg::USC_TX_STOP) begin
      break_request <= 1'b0;
    end
  end
  // shift-empty flag and pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_empty_flag          <= 1'b1;
      serial_tx_pin <= 1'b1;
      tx_pin_owned  <= 1'b0;
      rx_pin_owned  <= 1'b0;
      tx_irq        <= 1'b1;
    end else begin
      tx_shift_empty_flag <= !fifo_valid && tx_state == usc_pkg::USC_TX_IDLE && !fifo_pop;
      // idle level: plain line idles high unless inverted; encoded one the other way
      serial_tx_pin <= infrared_encode_enable ? (ctrl.tx_polarity_invert && tx_bit)
                                              : (tx_bit ^ ctrl.tx_polarity_invert);
      tx_pin_owned  <= tx_enabled;
      rx_pin_owned  <= ctrl.receiver_enable_bit && module_on;
      unique case (ctrl.tx_irq_mode_select)
        usc_pkg::USC_TXI_EMPTY: tx_irq <= !fifo_valid;
        usc_pkg::USC_TXI_DONE:  tx_irq <= tx_shift_empty_flag;
        usc_pkg::USC_TXI_SPACE: tx_irq <= fifo_in_ready;
        default:                tx_irq <= 1'b0; // reserved code
      endcase
    end
  end
  // ==========================================
  // receiver: synchronise pin, sample mid-bit
  logic       rx_s1;
  logic       rx_s2;
  logic [3:0] rx_cnt;
  logic [7:0] rx_sh;
  logic [15:0] rx_div;
  logic       rx_busy;
  logic       rx_in;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= serial_rx_pin;
      rx_s2 <= rx_s1;
    end
  end
  // a released pin reads as mark, so a stray low never starts a frame
  assign rx_in = rx_pin_owned ? rx_s2 : 1'b1;
  // start edge arms a half-bit count so each sample lands mid-bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy <= 1'b0;
      rx_div  <= '0;
      rx_cnt  <= '0;
      rx_sh   <= '0;
    end else if (!rx_busy) begin
      rx_div <= 16'(`USC_BAUD_DIV >> 1);
      rx_cnt <= '0;
      rx_busy <= !rx_in;
    end else if (rx_div != '0) begin
      rx_div <= 16'(rx_div - 1'b1);
    end else begin
      rx_div <= `USC_BAUD_DIV;
      rx_cnt <= 4'(rx_cnt + 1'b1);
      if (rx_cnt >= 4'h1 && rx_cnt <= 4'h8) rx_sh <= {rx_in, rx_sh[7:1]};
      if (rx_cnt == 4'h9) rx_busy <= 1'b0;
    end
  end
  // receive data, address filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf            <= '0;
      rx_data_available <= 1'b0;
      addr_matched      <= 1'b0;
    end else if (rx_busy && rx_div == '0 && rx_cnt == 4'h9 && rx_in) begin
      if (!ctrl.auto_addr_detect_enable || addr_matched) begin
        rx_buf            <= rx_sh;
        rx_data_available <= 1'b1; // set wins over read clear
      end else if (rx_sh == ctrl.addr_char) begin
        addr_matched <= 1'b1;
      end
    end else begin
      if (acc && !pwrite && paddr == `USC_ADDR_RXDATA) rx_data_available <= 1'b0;
      if (!ctrl.auto_addr_detect_enable) addr_matched <= 1'b0;
    end
  end
  // ==========================================
  // checks
  // break steps: an idle tick with a request pending starts the long low frame
  sequence s_brk_begin;
    tx_enabled && bit_tick && break_request && tx_state == usc_pkg::USC_TX_IDLE;
  endsequence
  sequence s_brk_low;
    brk_active && !tx_bit && tx_state == usc_pkg::USC_TX_START;
  endsequence
  a_brk_start: assert property (@(posedge pclk) disable iff (!presetn)
    s_brk_begin |-> !fifo_pop ##1 s_brk_low)
    else $error("break did not start cleanly");
  a_brk_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(break_request) |-> $past(tx_state) == usc_pkg::USC_TX_STOP)
    else $error("break request cleared outside stop");
  a_full_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && paddr == `USC_ADDR_STA)
    |-> prdata[`USC_TXBF_BIT] == !$past(fifo_in_ready, 1))
    else $error("full flag mismatch");
  a_top_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:25] == 7'h00)
    else $error("upper bits not zero");
  a_tx_abort: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.transmitter_enable_bit |=> !fifo_valid)
    else $error("buffer kept after disable");
  a_tx_shift_empty_flag_idle: assert property (@(posedge pclk) disable iff (!presetn)
    tx_shift_empty_flag |-> $past(tx_state) == usc_pkg::USC_TX_IDLE)
    else $error("shift empty while busy");
  a_irq_empty: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ctrl.tx_irq_mode_select) == usc_pkg::USC_TXI_EMPTY
    |-> tx_irq == !$past(fifo_valid))
    else $error("empty mode interrupt wrong");
  a_irq_space: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ctrl.tx_irq_mode_select) == usc_pkg::USC_TXI_SPACE
    |-> tx_irq == $past(fifo_in_ready))
    else $error("space mode interrupt wrong");
  a_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ctrl.tx_irq_mode_select) == usc_pkg::USC_TXI_DONE |-> tx_irq == $past(tx_shift_empty_flag))
    else $error("done mode interrupt wrong");
  a_pin_owner: assert property (@(posedge pclk) disable iff (!presetn)
    tx_pin_owned == $past(ctrl.transmitter_enable_bit && module_on))
    else $error("tx pin ownership wrong");
  a_rx_owner: assert property (@(posedge pclk) disable iff (!presetn)
    rx_pin_owned == $past(ctrl.receiver_enable_bit && module_on))
    else $error("rx pin ownership wrong");
  a_addr_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_busy && rx_div == '0 && rx_cnt == 4'h9
     && ctrl.auto_addr_detect_enable && !addr_matched) |=> $stable(rx_buf))
    else $error("character kept before address match");
  a_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
    $past(tx_state == usc_pkg::USC_TX_IDLE && !infrared_encode_enable && tx_bit)
    |-> serial_tx_pin == !$past(ctrl.tx_polarity_invert))
    else $error("idle level wrong");
endmodule

// File: rtl/usc_map.svh
`ifndef USC_MAP_SVH
`define USC_MAP_SVH
// register byte addresses
`define USC_ADDR_STA      12'h000
`define USC_ADDR_MODE     12'h004
`define USC_ADDR_TXDATA   12'h008
`define USC_ADDR_RXDATA   12'h00C
// status-and-control field positions
`define USC_AUTO_ADDR_DETECT_ENABLE_BIT    24
`define USC_ADDR_LSB      16
`define USC_TXISEL_LSB    14
`define USC_TXINV_BIT     13
`define USC_RXEN_BIT      12
`define USC_BRK_BIT       11
`define USC_TXEN_BIT      10
`define USC_TXBF_BIT      9
`define USC_TX_SHIFT_EMPTY_FLAG_BIT      8
`define USC_RXDA_BIT      0
// mode register field positions
`define USC_ON_BIT        15
`define USC_INFRARED_ENCODE_ENABLE_BIT      12
// status-and-control reset value
`define USC_STA_RESET     32'h0000_0100
// frame shape
`define USC_BRK_ZEROS     12
`define USC_DATA_BITS     8
`define USC_BAUD_DIV      16'h00D9
`endif

// File: rtl/usc_pkg.sv
package usc_pkg;
  typedef enum logic [1:0] {
    USC_TXI_SPACE = 2'h0,
    USC_TXI_DONE  = 2'h1,
    USC_TXI_EMPTY = 2'h2,
    USC_TXI_RSVD  = 2'h3
  } usc_txi_e;
  typedef struct packed {
    logic       auto_addr_detect_enable;
    logic [7:0] addr_char;
    usc_txi_e   tx_irq_mode_select;
    logic       tx_polarity_invert;
    logic       receiver_enable_bit;
    logic       transmitter_enable_bit;
  } usc_ctrl_s;
  typedef enum logic [3:0] {
    USC_TX_IDLE  = 4'h1,
    USC_TX_START = 4'h2,
    USC_TX_DATA  = 4'h4,
    USC_TX_STOP  = 4'h8
  } usc_tx_e;
endpackage

// File: rtl/usc_fifo.sv
`timescale 1ns/1ps
// ==========================================
// small synchronous fifo
module usc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // storage, flops only
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
  // pointers; flush drops everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else if (flush) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) wptr <= AW'(wptr + 1'b1);
      if (pop) rptr <= AW'(rptr + 1'b1);
      count <= (AW+1)'(count + push - pop);
    end
  end
endmodule

// File: test/usc_peer.sv
`timescale 1ns/1ps
// ==========================================
// remote serial peer: frame listener and frame sender
module usc_peer #(
  parameter int BT = 218
) (
  input  wire logic pclk,
  input  wire logic listen,
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [8:0] got[$];
  int         run = 0;
  int         max_low = 0;
  // 8N1 decode at mid-bit, pushes {stop, data}; a break shows stop low
  initial begin
    logic [7:0] d;
    forever begin
      @(posedge pclk);
      if (listen && tx_line === 1'b0) begin
        repeat (BT / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BT) @(posedge pclk);
          d[i] = tx_line;
        end
        repeat (BT) @(posedge pclk);
        got.push_back({tx_line, d});
        while (tx_line !== 1'b1) @(posedge pclk);
      end
    end
  end
  // longest low run in cycles, to size a break
  always @(posedge pclk) begin
    run = (tx_line === 1'b0) ? run + 1 : 0;
    if (run > max_low) max_low = run;
  end
  // line rests at mark between frames
  initial rx_line = 1'b1;
  // lsb first, changes only just after an edge
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BT) @(posedge pclk);
    end
  endtask
endmodule

// File: test/uart_status_control_reg_tb.sv
`timescale 1ns/1ps
`include "usc_map.svh"
// ==========================================
// bench: apb master, serial peer, frame queue model
module uart_status_control_reg_tb;
  localparam int BT = `USC_BAUD_DIV + 1;
  localparam logic [11:0] STA = `USC_ADDR_STA;
  localparam logic [11:0] MODE = `USC_ADDR_MODE;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        tx_line;
  logic        tx_own;
  logic        rx_own;
  logic        tx_irq;
  logic        listen;
  logic        err;
  logic [31:0] r;
  logic [7:0]  b;
  logic [8:0]  expq[$];
  int          mismatches = 0;
  int          compares = 0;
  int          cyc = 0;

  usc_uart #(.DEPTH(16)) u_usc_uart (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_rx_pin(rx_line), .serial_tx_pin(tx_line),
    .tx_pin_owned(tx_own), .rx_pin_owned(rx_own), .tx_irq(tx_irq));
  usc_peer #(.BT(BT)) u_usc_peer (.pclk(pclk), .listen(listen), .tx_line(tx_line),
    .rx_line(rx_line));

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; listen = 1'b0;
  end
  always #2.5 pclk = ~pclk;
  // hang guard, well above the frame traffic below
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    do rd(STA); while ((r & m) !== v);
  endtask
  task automatic tx(input int n);
    for (int i = 0; i < n; i++) begin
      b = $urandom;
      apb(1'b1, `USC_ADDR_TXDATA, {24'h0, b});
      expq.push_back({1'b1, b});
    end
  endtask
  task automatic rx(input logic [7:0] v);
    u_usc_peer.send(v);
    repeat (BT / 2) @(posedge pclk);
  endtask
  task automatic frames;
    check(u_usc_peer.got.size(), expq.size());
    while (expq.size() > 0 && u_usc_peer.got.size() > 0)
      check(u_usc_peer.got.pop_front(), expq.pop_front());
  endtask
  task automatic wait_irq;
    int n = 0;
    while (tx_irq !== 1'b1 && n < 12 * BT) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // modes 00, 01 and 10 only; 11 is never written
  initial begin
    void'($urandom(12));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(STA); check(r, `USC_STA_RESET);
    check(tx_irq, 1);
    rd(12'h010); check({r[30:0], err}, 1);
    $display("test reset done");
    // address detect: drop until the match, then accept
    apb(1'b1, STA, 32'hFF5A_1400); rd(STA); check(r, 32'h015A_1500);
    check({tx_own, rx_own}, 0);
    apb(1'b1, MODE, 32'h8000); repeat (2) @(posedge pclk);
    check({tx_own, rx_own}, 3);
    rx(8'h11); rd(STA); check(r[0], 0);
    rx(8'h5A); rd(`USC_ADDR_RXDATA);
    b = $urandom; rx(b); rd(STA); check(r[0], 1);
    rd(`USC_ADDR_RXDATA); check(r[7:0], b);
    apb(1'b1, STA, 32'h0400); repeat (2) @(posedge pclk); check(rx_own, 0);
    rx(8'hA5); rd(STA); check(r[0], 0);
    $display("test receive done");
    // completion interrupt, then empty-buffer interrupt
    listen <= 1'b1;
    apb(1'b1, STA, 32'h4400); tx(1); repeat (4) @(posedge pclk);
    check(tx_irq, 0);
    rd(STA); check(r[8], 0);
    wait_irq(); check(tx_irq, 1);
    rd(STA); check(r[8], 1);
    frames();
    apb(1'b1, STA, 32'h8400); repeat (2) @(posedge pclk); check(tx_irq, 1);
    tx(2); repeat (4) @(posedge pclk); check(tx_irq, 0);
    poll(32'h100, 32'h100); repeat (2) @(posedge pclk); check(tx_irq, 1);
    repeat (BT) @(posedge pclk); frames();
    $display("test transmit done");
    // overfill, then abort by clearing the enable
    listen <= 1'b0;
    apb(1'b1, STA, 32'h0400); tx(20); rd(STA);
    check(r[9], 1);
    check(tx_irq, 0);
    apb(1'b1, STA, 32'h0); repeat (2) @(posedge pclk); // shift-empty flag lags the flush
    rd(STA); check(r, 32'h0100);
    check(tx_own, 0);
    check(tx_irq, 1);
    repeat (12 * BT) @(posedge pclk);
    expq.delete(); u_usc_peer.got.delete(); listen <= 1'b1;
    apb(1'b1, STA, 32'h0400); repeat (12 * BT) @(posedge pclk); frames();
    $display("test abort done");
    // break: start plus twelve zeros held low, bit clears itself
    apb(1'b1, STA, 32'h0C00); apb(1'b1, `USC_ADDR_TXDATA, 32'h55);
    poll(32'h0900, 32'h0100); repeat (BT) @(posedge pclk);
    check(u_usc_peer.got.size(), 2);
    check(u_usc_peer.got.pop_front(), 0);
    check(u_usc_peer.got.pop_front(), {1'b1, 8'h55});
    check(u_usc_peer.max_low, (`USC_BRK_ZEROS + 1) * BT);
    $display("test break done");
    // idle level for each polarity and infrared setting
    listen <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, MODE, 32'h8000 | (k[1] << `USC_INFRARED_ENCODE_ENABLE_BIT));
      apb(1'b1, STA, 32'h0400 | (k[0] << `USC_TXINV_BIT)); repeat (4) @(posedge pclk);
      check(tx_line, k[1] ? k[0] : !k[0]);
    end
    $display("test polarity done");
    tally_and_finish();
  end
endmodule
